// File: core/rtmc_pkg.sv
// Shared constants and types for the mode command buffering block
`default_nettype none
package rtmc_pkg;
  // Register offsets on the host register port
  localparam logic [4:0]  REG_CFG_OFS      = 5'h17;
  localparam logic [4:0]  REG_BIT_PRI_OFS  = 5'h1e;
  localparam logic [4:0]  REG_BIT_ALT_OFS  = 5'h1f;
  localparam logic [15:0] CFG_RST_VAL      = 16'h0000;
  localparam logic [15:0] BIT_RST_VAL      = 16'h0000;
  // Terminal configuration fields
  localparam int          CFG_SIMPLIFIED_MODE_BUFFERING_POS     = 0;
  localparam int          CFG_ALTERNATE_SELFTEST_WORD_SELECT_POS  = 1;
  // Control word flags
  localparam int          CW_BROADCAST_RECEIVED_FLAG_POS     = 9;
  localparam int          CW_BLOCK_ACCESSED_FLAG_POS      = 11;
  // Descriptor word indexes within a 4-word block
  localparam logic [1:0]  DW_CTRL          = 2'h0;
  localparam logic [1:0]  DW_INFO          = 2'h1;
  localparam logic [1:0]  DW_TIME          = 2'h2;
  localparam logic [1:0]  DW_DATA          = 2'h3;
  localparam logic [1:0]  DW_BUF_PTR       = 2'h1;
  // Word offsets within a standard mode data buffer
  localparam logic [1:0]  BUF_INFO         = 2'h0;
  localparam logic [1:0]  BUF_TIME         = 2'h1;
  localparam logic [1:0]  BUF_DATA         = 2'h2;
  // Command word fields and mode codes
  localparam int          CMD_TR_POS       = 10;
  localparam logic [4:0]  MC_TX_VECTOR     = 5'h10;
  localparam logic [4:0]  MC_TX_LAST_CMD   = 5'h12;
  localparam logic [4:0]  MC_TX_SELFTEST   = 5'h13;
  localparam logic [12:0] DESC_BASE_RST    = 13'h0200;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0000,
    ST_RD_PTR = 4'b0001,
    ST_RD_DAT = 4'b0010,
    ST_TX_OUT = 4'b0011,
    ST_WAIT   = 4'b0100,
    ST_RD_CW  = 4'b0101,
    ST_WR_CW  = 4'b0110,
    ST_WR_INF = 4'b0111,
    ST_WR_TT  = 4'b1000,
    ST_WR_DAT = 4'b1001
  } rtmc_state_t;
endpackage
`default_nettype wire

// File: core/rtmc_regs.sv
// Host registers: terminal configuration and the two self-test words
`timescale 1ns/1ps
`default_nettype none
module rtmc_regs (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic        reg_wr_i,
  input  wire logic [4:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic      [15:0] reg_rdata_o,
  output logic      [15:0] cfg_o,
  output logic      [15:0] bit_pri_o,
  output logic      [15:0] bit_alt_o
);
  import rtmc_pkg::*;

  logic [15:0] cfg_ff, nxt_cfg, pri_ff, nxt_pri, alt_ff, nxt_alt;

  // Next values from host writes
  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_pri = pri_ff;
    nxt_alt = alt_ff;
    if (reg_wr_i) begin
      if (reg_addr_i == REG_CFG_OFS)     nxt_cfg = reg_wdata_i;
      if (reg_addr_i == REG_BIT_PRI_OFS) nxt_pri = reg_wdata_i;
      if (reg_addr_i == REG_BIT_ALT_OFS) nxt_alt = reg_wdata_i;
    end
  end

  // Register stage
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cfg_ff <= CFG_RST_VAL;
      pri_ff <= BIT_RST_VAL;
      alt_ff <= BIT_RST_VAL;
    end else begin
      cfg_ff <= nxt_cfg;
      pri_ff <= nxt_pri;
      alt_ff <= nxt_alt;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    case (reg_addr_i)
      REG_CFG_OFS:     reg_rdata_o = cfg_ff;
      REG_BIT_PRI_OFS: reg_rdata_o = pri_ff;
      REG_BIT_ALT_OFS: reg_rdata_o = alt_ff;
      default:         reg_rdata_o = 16'h0000;
    endcase
  end

  assign cfg_o     = cfg_ff;
  assign bit_pri_o = pri_ff;
  assign bit_alt_o = alt_ff;
endmodule
`default_nettype wire

// File: core/rtmc_txsel.sv
// Chooses the outgoing mode data word for a transmit mode command
`timescale 1ns/1ps
`default_nettype none
module rtmc_txsel (
  input  wire logic [4:0]  code_i,
  input  wire logic        alt_sel_i,
  input  wire logic [15:0] last_cmd_i,
  input  wire logic [15:0] bit_pri_i,
  input  wire logic [15:0] bit_alt_i,
  input  wire logic [15:0] mem_word_i,
  output logic      [15:0] word_o
);
  import rtmc_pkg::*;

  // [RL6] [RL7] Last command and self-test word never come from memory
  always_comb begin
    if (code_i == MC_TX_LAST_CMD)      word_o = last_cmd_i;
    else if (code_i == MC_TX_SELFTEST) word_o = alt_sel_i ? bit_alt_i : bit_pri_i;
    else                               word_o = mem_word_i;
  end
endmodule
`default_nettype wire

// File: core/rtmc_core.sv
// Mode command data storage and retrieval engine, top level
//
// Overview of operation
// [RL1] Standard scheme uses only a descriptor-held buffer pointer, no circular buffers.
// [RL2] Host should pick single-message index mode for indexed mode buffers.
// [RL3] Standard scheme, codes 0-15: write only info and time-tag buffer words.
// [RL4] Standard scheme, received 16-31: store data word plus info and time tag.
// [RL5] Standard scheme, transmit 16-31: fetch data word from the assigned buffer.
// [RL6] Transmit-last-command word is generated internally, never read from memory.
// [RL7] Self-test word comes from primary or alternate register per config bit.
// [RL8] Standard scheme: record sent last-command/self-test word, info and time tag.
// [RL9] Simplified bit acts on all mode commands; descriptors then hold no pointer.
// [RL10] Simplified block order: control, info, time tag, mode data word.
// [RL11] Simplified scheme updates only accessed and broadcast control-word bits.
// [RL12] Host may preload descriptor word 4; otherwise zero is sent.
// [RL13] Simplified, codes 0-15: update words 1-3, never descriptor word 4.
// [RL14] Simplified, received 16-31: store data in word 4, update words 1-3.
// [RL15] Simplified, transmit 16-31: outgoing word read from descriptor word 4.
// [RL16] Simplified: sent last-command/self-test word copied to word 4, words 1-3 updated.
// [RL17] Codes 0-15 carry no data word; 16-31 carry one, direction by T/R.
// [RL18] Illegal codes 16-31 move no data word; status-only response.
`timescale 1ns/1ps
`default_nettype none
module rtmc_core #(
  parameter int               ADDR_W    = 13,
  parameter logic [ADDR_W-1:0] DESC_BASE = rtmc_pkg::DESC_BASE_RST
) (
  input  wire logic              clk_sys_i,
  input  wire logic              rst_n_i,
  input  wire logic              reg_wr_i,
  input  wire logic [4:0]        reg_addr_i,
  input  wire logic [15:0]       reg_wdata_i,
  output logic      [15:0]       reg_rdata_o,
  input  wire logic              cmd_start_i,
  input  wire logic [15:0]       cmd_word_i,
  input  wire logic              cmd_broadcast_received_flag_i,
  input  wire logic              cmd_illegal_i,
  input  wire logic              msg_done_i,
  input  wire logic [15:0]       msg_info_i,
  input  wire logic [15:0]       msg_time_i,
  input  wire logic [15:0]       rx_data_i,
  output logic      [15:0]       tx_word_o,
  output logic                   tx_word_valid_o,
  output logic                   busy_o,
  output logic                   ram_req_o,
  output logic                   ram_we_o,
  output logic      [ADDR_W-1:0] ram_addr_o,
  output logic      [15:0]       ram_wdata_o,
  input  wire logic [15:0]       ram_rdata_i,
  input  wire logic              ram_ack_i
);
  import rtmc_pkg::*;

  // ****************************************************************
  // Configuration registers and transmit word selection
  // ****************************************************************
  logic [15:0] cfg, bit_pri, bit_alt, sel_word;

  rtmc_regs u_regs (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .reg_wr_i    (reg_wr_i),
    .reg_addr_i  (reg_addr_i),
    .reg_wdata_i (reg_wdata_i),
    .reg_rdata_o (reg_rdata_o),
    .cfg_o       (cfg),
    .bit_pri_o   (bit_pri),
    .bit_alt_o   (bit_alt)
  );

  rtmc_state_t state_ff, nxt_state;
  logic [15:0] cmd_ff, nxt_cmd, last_cmd_ff, nxt_last_cmd;
  logic [15:0] txw_ff, nxt_txw, cw_ff, nxt_cw, dword_ff, nxt_dword;
  logic [15:0] info_ff, nxt_info, time_ff, nxt_time;
  logic [ADDR_W-1:0] ptr_ff, nxt_ptr;
  logic        broadcast_received_flag_ff, nxt_broadcast_received_flag, ill_ff, nxt_ill, simplified_mode_buffering_ff, nxt_simplified_mode_buffering;

  // [RL7] Self-test word source
  rtmc_txsel u_txsel (
    .code_i     (cmd_ff[4:0]),
    .alt_sel_i  (cfg[CFG_ALTERNATE_SELFTEST_WORD_SELECT_POS]),
    .last_cmd_i (last_cmd_ff),
    .bit_pri_i  (bit_pri),
    .bit_alt_i  (bit_alt),
    .mem_word_i (ram_rdata_i),
    .word_o     (sel_word)
  );

  // ****************************************************************
  // Command decode
  // ****************************************************************
  logic [4:0]        code;
  logic              is_tx, has_data, int_word;
  logic [ADDR_W-1:0] desc_addr;

  // [RL17] [RL18] Data word only for codes 16-31; illegal ones move none
  assign code      = cmd_ff[4:0];
  assign is_tx     = cmd_ff[CMD_TR_POS];
  assign has_data  = code[4] && !ill_ff;
  assign int_word  = (code == MC_TX_LAST_CMD) || (code == MC_TX_SELFTEST);
  // [RL10] One 4-word block per mode code and direction
  assign desc_addr = DESC_BASE + ADDR_W'({is_tx, code, 2'b00});

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // One RAM access at a time; request held until acknowledged
  always_comb begin
    nxt_state    = state_ff;
    nxt_cmd      = cmd_ff;
    nxt_last_cmd = last_cmd_ff;
    nxt_txw      = txw_ff;
    nxt_cw       = cw_ff;
    nxt_dword    = dword_ff;
    nxt_info     = info_ff;
    nxt_time     = time_ff;
    nxt_ptr      = ptr_ff;
    nxt_broadcast_received_flag    = broadcast_received_flag_ff;
    nxt_ill      = ill_ff;
    nxt_simplified_mode_buffering     = simplified_mode_buffering_ff;
    case (state_ff)
      ST_IDLE: begin
        if (cmd_start_i) begin
          nxt_cmd   = cmd_word_i;
          nxt_broadcast_received_flag = cmd_broadcast_received_flag_i;
          nxt_ill   = cmd_illegal_i;
          // [RL9] Scheme latched per command, global for all codes
          nxt_simplified_mode_buffering  = cfg[CFG_SIMPLIFIED_MODE_BUFFERING_POS];
          nxt_state = cfg[CFG_SIMPLIFIED_MODE_BUFFERING_POS] ? ST_WAIT : ST_RD_PTR;
          if (cfg[CFG_SIMPLIFIED_MODE_BUFFERING_POS] && cmd_word_i[CMD_TR_POS] && cmd_word_i[4]
              && !cmd_illegal_i)
            nxt_state = ST_RD_DAT;
        end
      end
      ST_RD_PTR: begin
        if (ram_ack_i) begin
          // [RL1] Pointer names an indexed or ping-pong buffer
          nxt_ptr = ram_rdata_i[ADDR_W-1:0];
          if (is_tx && has_data && !int_word) nxt_state = ST_RD_DAT;
          else if (is_tx && has_data)         nxt_state = ST_TX_OUT;
          else                                nxt_state = ST_WAIT;
        end
      end
      ST_RD_DAT: begin
        if (int_word) begin
          nxt_state = ST_TX_OUT;
        end else if (ram_ack_i) begin
          nxt_state = ST_TX_OUT;
        end
      end
      ST_TX_OUT: begin
        nxt_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (msg_done_i) begin
          nxt_info  = msg_info_i;
          nxt_time  = msg_time_i;
          // Data recorded is the word actually moved on the bus
          nxt_dword = is_tx ? txw_ff : rx_data_i;
          // Transmit-last-command must not overwrite its own answer
          if (code != MC_TX_LAST_CMD || !is_tx) nxt_last_cmd = cmd_ff;
          nxt_state = simplified_mode_buffering_ff ? ST_RD_CW : ST_WR_INF;
        end
      end
      ST_RD_CW: begin
        if (ram_ack_i) begin
          // [RL11] Touch only the accessed and broadcast bits
          nxt_cw = ram_rdata_i;
          nxt_cw[CW_BLOCK_ACCESSED_FLAG_POS]  = 1'b1;
          nxt_cw[CW_BROADCAST_RECEIVED_FLAG_POS] = broadcast_received_flag_ff;
          nxt_state = ST_WR_CW;
        end
      end
      ST_WR_CW:  if (ram_ack_i) nxt_state = ST_WR_INF;
      ST_WR_INF: if (ram_ack_i) nxt_state = ST_WR_TT;
      // [RL13] No word 4 write without a data word
      ST_WR_TT:  if (ram_ack_i) nxt_state = has_data ? ST_WR_DAT : ST_IDLE;
      ST_WR_DAT: if (ram_ack_i) nxt_state = ST_IDLE;
      default:   nxt_state = ST_IDLE;
    endcase
    // Load the outgoing word on entry to the transmit slot
    if (nxt_state == ST_TX_OUT && state_ff != ST_TX_OUT) nxt_txw = sel_word;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_ff    <= ST_IDLE;
      cmd_ff      <= 16'h0000;
      last_cmd_ff <= 16'h0000;
      txw_ff      <= 16'h0000;
      cw_ff       <= 16'h0000;
      dword_ff    <= 16'h0000;
      info_ff     <= 16'h0000;
      time_ff     <= 16'h0000;
      ptr_ff      <= '0;
      broadcast_received_flag_ff    <= 1'b0;
      ill_ff      <= 1'b0;
      simplified_mode_buffering_ff     <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      cmd_ff      <= nxt_cmd;
      last_cmd_ff <= nxt_last_cmd;
      txw_ff      <= nxt_txw;
      cw_ff       <= nxt_cw;
      dword_ff    <= nxt_dword;
      info_ff     <= nxt_info;
      time_ff     <= nxt_time;
      ptr_ff      <= nxt_ptr;
      broadcast_received_flag_ff    <= nxt_broadcast_received_flag;
      ill_ff      <= nxt_ill;
      simplified_mode_buffering_ff     <= nxt_simplified_mode_buffering;
    end
  end

  // ****************************************************************
  // Shared RAM port
  // ****************************************************************
  // Addresses: descriptor words when simplified; otherwise descriptor pointer word, then buffer words
  always_comb begin
    ram_req_o   = 1'b1;
    ram_we_o    = 1'b0;
    ram_wdata_o = 16'h0000;
    ram_addr_o  = desc_addr;
    case (state_ff)
      ST_RD_PTR: ram_addr_o = desc_addr + ADDR_W'(DW_BUF_PTR);
      // [RL5] [RL12] [RL15] Word 4 or buffer word, as the host preloaded it
      ST_RD_DAT: begin
        ram_req_o  = !int_word;
        ram_addr_o = simplified_mode_buffering_ff ? desc_addr + ADDR_W'(DW_DATA)
                             : ptr_ff + ADDR_W'(BUF_DATA);
      end
      ST_RD_CW:  ram_addr_o = desc_addr + ADDR_W'(DW_CTRL);
      ST_WR_CW: begin
        ram_we_o    = 1'b1;
        ram_wdata_o = cw_ff;
      end
      // [RL3] Info and time tag written for every completed command
      ST_WR_INF: begin
        ram_we_o    = 1'b1;
        ram_wdata_o = info_ff;
        ram_addr_o  = simplified_mode_buffering_ff ? desc_addr + ADDR_W'(DW_INFO)
                              : ptr_ff + ADDR_W'(BUF_INFO);
      end
      ST_WR_TT: begin
        ram_we_o    = 1'b1;
        ram_wdata_o = time_ff;
        ram_addr_o  = simplified_mode_buffering_ff ? desc_addr + ADDR_W'(DW_TIME)
                              : ptr_ff + ADDR_W'(BUF_TIME);
      end
      // [RL4] [RL8] [RL14] [RL16] Data word stored after completion
      ST_WR_DAT: begin
        ram_we_o    = 1'b1;
        ram_wdata_o = dword_ff;
        ram_addr_o  = simplified_mode_buffering_ff ? desc_addr + ADDR_W'(DW_DATA)
                              : ptr_ff + ADDR_W'(BUF_DATA);
      end
      default:   ram_req_o = 1'b0;
    endcase
  end

  // Transmit word handed to the encoder for exactly one cycle
  assign tx_word_o       = txw_ff;
  assign tx_word_valid_o = (state_ff == ST_TX_OUT);
  assign busy_o          = (state_ff != ST_IDLE);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_fetch_done;
    state_ff == ST_RD_DAT && ram_req_o && ram_ack_i;
  endsequence
  sequence s_tx_slot;
    ##1 (tx_word_valid_o && tx_word_o == $past(ram_rdata_i));
  endsequence

  property p_tx_only_legal_data;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      tx_word_valid_o |-> code[4] && is_tx && !ill_ff;
  endproperty
  a_tx_only_legal_data: assert property (p_tx_only_legal_data) // [RL18]
    else $error("Data word sent for a code without one");

  property p_fetch_then_send;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      s_fetch_done |-> s_tx_slot;
  endproperty
  a_fetch_then_send: assert property (p_fetch_then_send) // [RL5]
    else $error("Fetched word not sent next cycle");

  property p_last_cmd_word;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      tx_word_valid_o && code == MC_TX_LAST_CMD |-> tx_word_o == last_cmd_ff;
  endproperty
  a_last_cmd_word: assert property (p_last_cmd_word) // [RL6]
    else $error("Last command word mismatch");

  property p_no_mem_internal;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      state_ff == ST_RD_DAT && int_word |-> !ram_req_o;
  endproperty
  a_no_mem_internal: assert property (p_no_mem_internal) // [RL6]
    else $error("Memory read for internally made word");

  property p_selftest_word;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      tx_word_valid_o && code == MC_TX_SELFTEST
        |-> tx_word_o == (cfg[CFG_ALTERNATE_SELFTEST_WORD_SELECT_POS] ? bit_alt : bit_pri);
  endproperty
  a_selftest_word: assert property (p_selftest_word) // [RL7]
    else $error("Self-test word from wrong register");

  property p_word4_untouched;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      ram_req_o && ram_we_o && simplified_mode_buffering_ff && !code[4]
        |-> ram_addr_o != desc_addr + ADDR_W'(DW_DATA);
  endproperty
  a_word4_untouched: assert property (p_word4_untouched) // [RL13]
    else $error("Word 4 written for a code without data");

  property p_cw_flags;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      state_ff == ST_RD_CW && ram_ack_i |=> ram_we_o && ram_wdata_o[CW_BLOCK_ACCESSED_FLAG_POS]
        && ram_wdata_o[CW_BROADCAST_RECEIVED_FLAG_POS] == broadcast_received_flag_ff
        && ram_addr_o == desc_addr;
  endproperty
  a_cw_flags: assert property (p_cw_flags) // [RL11]
    else $error("Control word flags wrong");

  property p_std_no_cw;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      !simplified_mode_buffering_ff |-> state_ff != ST_RD_CW && state_ff != ST_WR_CW;
  endproperty
  a_std_no_cw: assert property (p_std_no_cw) // [RL9]
    else $error("Control word touched in standard scheme");

  property p_sent_word_recorded;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      state_ff == ST_WR_DAT && is_tx |-> ram_wdata_o == txw_ff;
  endproperty
  a_sent_word_recorded: assert property (p_sent_word_recorded) // [RL16]
    else $error("Recorded word differs from sent word");
endmodule
`default_nettype wire

// File: dv/rtmc_ram_model.sv
// Shared RAM model seen by the mode command engine, with adjustable latency
`timescale 1ns/1ps
`default_nettype none
module rtmc_ram_model (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic [1:0]  lat_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [12:0] addr_i,
  input  wire logic [15:0] wdata_i,
  output logic      [15:0] rdata_o,
  output logic             ack_o
);
  logic [15:0] mem [0:8191];
  logic [1:0]  wait_ff;

  // Ack after lat_i extra cycles; outside the ack cycle read data toggles,
  // so a design that samples late never sees a plausible stale word
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ack_o   <= 1'b0;
      wait_ff <= 2'h0;
      rdata_o <= 16'h0000;
    end else if (req_i && !ack_o && wait_ff == lat_i) begin
      ack_o   <= 1'b1;
      wait_ff <= 2'h0;
      rdata_o <= mem[addr_i];
      if (we_i) begin
        mem[addr_i] <= wdata_i;
      end
    end else begin
      ack_o   <= 1'b0;
      rdata_o <= ~rdata_o;
      if (req_i && !ack_o) begin
        wait_ff <= wait_ff + 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// File: dv/test_rtmc_core.sv
// Self-checking bench for the mode command buffering engine
`timescale 1ns/1ps
`default_nettype none
module test_rtmc_core;
  import rtmc_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        reg_wr_i = 1'b0;
  logic [4:0]  reg_addr_i = 5'h00;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic [15:0] reg_rdata_o;
  logic        cmd_start_i = 1'b0;
  logic [15:0] cmd_word_i = 16'h0000;
  logic        cmd_broadcast_received_flag_i = 1'b0;
  logic        cmd_illegal_i = 1'b0;
  logic        msg_done_i = 1'b0;
  logic [15:0] msg_info_i = 16'h0000;
  logic [15:0] msg_time_i = 16'h0000;
  logic [15:0] rx_data_i = 16'h0000;
  logic [15:0] tx_word_o;
  logic        tx_word_valid_o;
  logic        busy_o;
  logic        ram_req_o;
  logic        ram_we_o;
  logic [12:0] ram_addr_o;
  logic [15:0] ram_wdata_o;
  logic [15:0] ram_rdata_i;
  logic        ram_ack_i;
  logic [1:0]  cfg = 2'h0;
  logic [15:0] seq = 16'h0000;
  logic [15:0] last_cmd = 16'h0000;
  int          miscompares = 0;
  int          total_checks = 0;
  // Each entry: mode code, T/R, broadcast, illegal
  localparam logic [7:0] CASES [8] = '{8'h1e, 8'h8a, 8'h84, 8'h94,
                                       8'h9c, 8'ha5, 8'ha9, 8'h48};

  always #10 clk_sys_i = ~clk_sys_i;

  rtmc_core i_rtmc_core (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .cmd_start_i(cmd_start_i), .cmd_word_i(cmd_word_i), .cmd_broadcast_received_flag_i(cmd_broadcast_received_flag_i),
    .cmd_illegal_i(cmd_illegal_i), .msg_done_i(msg_done_i), .msg_info_i(msg_info_i),
    .msg_time_i(msg_time_i), .rx_data_i(rx_data_i), .tx_word_o(tx_word_o),
    .tx_word_valid_o(tx_word_valid_o), .busy_o(busy_o), .ram_req_o(ram_req_o),
    .ram_we_o(ram_we_o), .ram_addr_o(ram_addr_o), .ram_wdata_o(ram_wdata_o),
    .ram_rdata_i(ram_rdata_i), .ram_ack_i(ram_ack_i));

  rtmc_ram_model i_rtmc_ram_model (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .lat_i(cfg),
    .req_i(ram_req_o), .we_i(ram_we_o), .addr_i(ram_addr_o), .wdata_i(ram_wdata_o),
    .rdata_o(ram_rdata_i), .ack_o(ram_ack_i));

  // Compare one value and count the outcome
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk_sys_i);
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(negedge clk_sys_i);
    reg_wr_i = 1'b0;
  endtask

  task automatic reg_rd(input logic [4:0] a, input logic [15:0] exp);
    @(negedge clk_sys_i);
    reg_addr_i = a;
    #1 check(reg_rdata_o, exp, "register read");
  endtask

  // One mode command: preload RAM, start, watch the data word, complete, check RAM
  task automatic run_cmd(input logic [7:0] c);
    logic [4:0]  code;
    logic        tr;
    logic        bc;
    logic        has_d;
    logic [12:0] dsc;
    logic [12:0] bfa;
    logic [12:0] inf_a;
    logic [15:0] word;
    logic [15:0] sent;
    logic [15:0] exp_tx;
    int          nval;
    code = c[7:3];
    tr = c[2];
    bc = c[1];
    has_d = code[4] & ~c[0];
    dsc = DESC_BASE_RST + {5'h00, tr, code, 2'h0};
    bfa = 13'h0800 + {5'h00, tr, code, 2'h0};
    inf_a = cfg[0] ? dsc + 13'h1 : bfa;
    seq = seq + 16'h1111;
    word = {5'h0b, tr, 5'h00, code};
    nval = 0;
    sent = 16'h0000;
    exp_tx = (code == MC_TX_LAST_CMD) ? last_cmd : seq;
    if (code == MC_TX_SELFTEST) begin
      exp_tx = cfg[1] ? 16'ha17e : 16'hb1e5;
    end
    // Index mode left at single message (field zero)
    i_rtmc_ram_model.mem[dsc] = 16'h0205;
    i_rtmc_ram_model.mem[dsc + 13'h1] = cfg[0] ? 16'h5a5a : {3'h0, bfa};
    i_rtmc_ram_model.mem[dsc + 13'h3] = seq;
    i_rtmc_ram_model.mem[bfa + 13'h2] = seq;
    @(negedge clk_sys_i);
    cmd_start_i = 1'b1;
    cmd_word_i = word;
    cmd_broadcast_received_flag_i = bc;
    cmd_illegal_i = c[0];
    @(negedge clk_sys_i);
    cmd_word_i = 16'h5805;
    for (int k = 0; k < 20; k++) begin
      @(negedge clk_sys_i);
      cmd_start_i = 1'b0;
      if (tx_word_valid_o === 1'b1) begin
        nval++;
        sent = tx_word_o;
      end
    end
    check(16'(nval), 16'(tr & has_d), "data word count");
    if (tr & has_d) begin
      check(sent, exp_tx, "transmit word");
    end
    msg_done_i = 1'b1;
    msg_info_i = seq ^ 16'h00f0;
    msg_time_i = seq ^ 16'h0f00;
    rx_data_i = seq ^ 16'hf000;
    @(negedge clk_sys_i);
    msg_done_i = 1'b0;
    for (int k = 0; k < 200 && busy_o !== 1'b0; k++) begin
      @(negedge clk_sys_i);
    end
    check({15'h0, busy_o}, 16'h0000, "completion");
    // Standard scheme must leave the control word alone
    check(i_rtmc_ram_model.mem[dsc], cfg[0] ? {4'h0, 2'b10, bc, 9'h005} : 16'h0205,
          "flags");
    check(i_rtmc_ram_model.mem[inf_a], seq ^ 16'h00f0, "info");
    check(i_rtmc_ram_model.mem[inf_a + 13'h1], seq ^ 16'h0f00, "time tag");
    check(i_rtmc_ram_model.mem[inf_a + 13'h2], !has_d ? seq : tr ? exp_tx : seq ^ 16'hf000,
          "data slot");
    if (!(tr && code == MC_TX_LAST_CMD)) begin
      last_cmd = word;
    end
  endtask

  initial begin
    repeat (2) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    reg_rd(REG_CFG_OFS, 16'h0000);
    reg_rd(REG_BIT_PRI_OFS, 16'h0000);
    reg_rd(REG_BIT_ALT_OFS, 16'h0000);
    reg_wr(REG_BIT_PRI_OFS, 16'hb1e5);
    reg_wr(REG_BIT_ALT_OFS, 16'ha17e);
    reg_wr(5'h05, 16'hffff);
    reg_rd(5'h05, 16'h0000);
    reg_rd(REG_BIT_PRI_OFS, 16'hb1e5);
    reg_rd(REG_BIT_ALT_OFS, 16'ha17e);
    // Every scheme and self-test source, each at its own RAM latency (latency follows cfg)
    for (int s = 0; s < 4; s++) begin
      @(negedge clk_sys_i);
      cfg = 2'(s);
      reg_wr(REG_CFG_OFS, {14'h0000, cfg});
      reg_rd(REG_CFG_OFS, {14'h0000, cfg});
      foreach (CASES[i]) begin
        run_cmd(CASES[i]);
      end
    end
    final_report();
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    miscompares++;
    final_report();
  end
endmodule
`default_nettype wire
